// [testbench/pin_source_model.sv]
// Purpose: outside party on one timer pin
// Assumes: the block drives the pin only while its enable is low
// Notes:   the bench sets the level the outside source presents
`timescale 1ns/10ps
`default_nettype none
module pin_source_model (
  input  wire logic oe_n,      // block enable, low drives
  input  wire logic dut_level, // block output level
  input  wire logic ext_level, // level of the outside source
  output logic      pin        // resolved wire level
);
  // the block wins while it drives, else the outside source
  assign pin = oe_n ? ext_level : dut_level;
endmodule
`default_nettype wire

// [testbench/test_timer_pin_io_mode_select.sv]
// Purpose: self-checking bench of the pin io mode select block
// Assumes: one-cycle wishbone answer, counters stopped while set up
// Notes:   captures are seen through the general registers
`timescale 1ns/10ps
`default_nettype none
module test_timer_pin_io_mode_select;
  import tpio_pkg::*;
  typedef struct packed {logic [3:0] f; logic oe_n; logic l0; logic l1; logic cr; logic cf;} row_t;
  logic clock = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, oc, oa, pc, pa, ic, ia;
  logic lc = 0, la = 0;
  logic [4:0] adr = '0;
  logic [31:0] dwr = '0, rdat, q;
  logic [15:0] v3, v4;
  int errors = 0, samples_checked = 0;
  row_t rows [12] = '{'{4'h0,1,0,0,0,0}, '{4'h1,0,0,0,0,0}, '{4'h2,0,0,1,0,0}, '{4'h3,0,0,1,0,0},
    '{4'h4,1,0,0,0,0}, '{4'h5,0,1,0,0,0}, '{4'h6,0,1,1,0,0}, '{4'h7,0,1,0,0,0},
    '{4'h8,1,0,0,1,0}, '{4'h9,1,0,0,0,1}, '{4'hA,1,0,0,1,1}, '{4'hB,1,0,0,1,1}};
  // clock of 20 ns
  always #10 clock = ~clock;
  timer_pin_io_mode_select u_dut (.CLOCK(clock), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dwr), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .PIN_C3_I(ic), .PIN_C3_O(pc), .PIN_C3_OE_N(oc),
    .PIN_A4_I(ia), .PIN_A4_O(pa), .PIN_A4_OE_N(oa));
  pin_source_model u_c3 (.oe_n(oc), .dut_level(pc), .ext_level(lc), .pin(ic));
  pin_source_model u_a4 (.oe_n(oa), .dut_level(pa), .ext_level(la), .pin(ia));
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: pin got %b exp %b", $time, got, exp);
    end
  endtask
  // one classic cycle, released at the ack edge
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dwr <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 40);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      errors++;
      $display("Error at %0t: no ack", $time);
      report_and_stop();
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // stopped counter values
  task automatic cnt();
    wb(0, 5'h18, 32'h0000_0000, q);
    v3 = q[15:0];
    v4 = q[31:16];
  endtask
  // ch3 counter runs past one match
  task automatic run3();
    wb(1, 5'h0C, 32'h0000_0001, q);
    wt(20);
    wb(1, 5'h0C, 32'h0000_0000, q);
  endtask
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    wt(12);
    chk_pin(oc, 1'b1);
    chk_pin(oa, 1'b1);
    rst <= 1'b0;
    wb(0, 5'h00, 0, q); chk_reg(q, {24'h0, IO_CONTROL_RESET});
    wb(0, 5'h04, 0, q); chk_reg(q, {24'h0, IO_CONTROL_RESET});
    wb(0, 5'h08, 0, q); chk_reg(q, {24'h0, MODE_RESET});
    wb(0, 5'h10, 0, q); chk_reg(q, {16'h0, GENERAL_RESET});
    wb(0, 5'h14, 0, q); chk_reg(q, {16'h0, GENERAL_RESET});
    wb(0, 5'h18, 0, q); chk_reg(q, {COUNTER_RESET, COUNTER_RESET});
    // ch3 register c: every compare code and the own-pin capture codes 8 to B
    foreach (rows[i]) begin
      cnt();
      wb(1, 5'h10, {16'h0, v3 + 16'h0005}, q);
      wb(1, 5'h00, {28'h0, rows[i].f}, q);
      wt(8);
      chk_pin(oc, rows[i].oe_n);
      if (!rows[i].oe_n) begin
        chk_pin(pc, rows[i].l0);
        run3();
        wt(2);
        chk_pin(pc, rows[i].l1);
      end
      if (rows[i].f[3]) begin
        wb(1, 5'h10, 32'h0000_A5A5, q);
        lc <= 1'b1;
        wt(8);
        wb(0, 5'h10, 0, q); chk_reg(q, rows[i].cr ? {16'h0, v3} : 32'h0000_A5A5);
        wb(1, 5'h10, 32'h0000_A5A5, q);
        lc <= 1'b0;
        wt(8);
        wb(0, 5'h10, 0, q); chk_reg(q, rows[i].cf ? {16'h0, v3} : 32'h0000_A5A5);
      end
    end
    // ch4 register a from its own pin
    cnt();
    wb(1, 5'h14, 32'h0000_A5A5, q);
    wb(1, 5'h04, 32'h0000_0008, q);
    wt(8);
    la <= 1'b1;
    wt(8);
    wb(0, 5'h14, 0, q); chk_reg(q, {16'h0, v4});
    // ch4 register a on ch3 register a match, pin ignored
    wb(1, 5'h00, 32'h0000_0000, q);
    wb(1, 5'h04, 32'h0000_000C, q);
    wb(1, 5'h14, 32'h0000_A5A5, q);
    wb(1, 5'h18, {16'h0, v3 + 16'h0005}, q);
    la <= 1'b0;
    wt(8);
    wb(0, 5'h14, 0, q); chk_reg(q, 32'h0000_A5A5);
    run3();
    wt(4);
    wb(0, 5'h14, 0, q); chk_reg(q, {16'h0, v4});
    // ch3 register c on ch4 counting up then down
    for (int k = 0; k < 2; k++) begin
      cnt();
      wb(1, 5'h00, 32'h0000_000C, q);
      wb(1, 5'h10, 32'h0000_A5A5, q);
      lc <= ~lc;
      wt(8);
      wb(0, 5'h10, 0, q); chk_reg(q, 32'h0000_A5A5);
      wb(1, 5'h0C, k ? 32'h0000_0006 : 32'h0000_0002, q);
      wt(5);
      wb(1, 5'h0C, 32'h0000_0000, q);
      wb(0, 5'h10, 0, q); chk_reg(q, {16'h0, v3});
    end
    // ch4 register a compare, pin high on match
    cnt();
    wb(1, 5'h14, {16'h0, v4 + 16'h0005}, q);
    wb(1, 5'h04, 32'h0000_0002, q);
    wt(2);
    chk_pin(oa, 1'b0);
    chk_pin(pa, 1'b0);
    wb(1, 5'h0C, 32'h0000_0002, q);
    wt(20);
    wb(1, 5'h0C, 32'h0000_0000, q);
    wt(2);
    chk_pin(pa, 1'b1);
    // buffer mode blocks register c
    wb(1, 5'h08, 32'h0000_0010, q);
    wb(1, 5'h00, 32'h0000_0003, q);
    wt(8);
    chk_pin(oc, 1'b1);
    wb(1, 5'h00, 32'h0000_0008, q);
    wb(1, 5'h10, 32'h0000_A5A5, q);
    lc <= ~lc;
    wt(8);
    lc <= ~lc;
    wt(8);
    wb(0, 5'h10, 0, q); chk_reg(q, 32'h0000_A5A5);
    // write to the read-only status word changes nothing
    wb(1, 5'h1C, 32'hFFFF_FFFF, q);
    wb(0, 5'h00, 0, q); chk_reg(q, 32'h0000_0008);
    // reset in mid-run brings back the idle pins and fields
    rst <= 1'b1;
    wt(2);
    chk_pin(oa, 1'b1);
    chk_pin(pa, 1'b0);
    rst <= 1'b0;
    wb(0, 5'h04, 0, q);
    chk_reg(q, {24'h0, IO_CONTROL_RESET});
    wb(0, 5'h08, 0, q);
    chk_reg(q, {24'h0, MODE_RESET});
    report_and_stop();
  end
endmodule
`default_nettype wire

// [verilog/timer_pin_io_mode_select.sv]
// Purpose: io function decode for channel 3 register c and channel 4 register a
// Assumes: pins are asynchronous; wishbone master on CLOCK
// Notes:   counters run every clock while enabled
//
// Contract
// - compare, bit2 clear starts pin low; bits1:0 zero disable output.
// - compare, bit2 set, bits1:0 nonzero starts pin high.
// - compare, bits1:0 = 01 drive pin low on match.
// - compare, bits1:0 = 10 drive pin high on match.
// - compare, bits1:0 = 11 toggle pin on match.
// - capture, bits1:0 = 00 capture on rising edge.
// - capture, bits1:0 = 01 capture on falling edge.
// - capture, bit1 set capture on both edges.
// - channel 3 register c captures from its own pin when bit2 clear.
// - channel 3 register c, bits3:2 set captures on channel 4 count.
// - channel 4 register a captures from its own pin when bit2 clear.
// - channel 4 register a, bits3:2 set captures on ch3 register a event.
// - buffer mode set disables channel 3 register c matches and captures.
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module timer_pin_io_mode_select
  import tpio_pkg::*;
(
  input  wire logic        CLOCK,      // 50 MHz clock
  input  wire logic        RST,        // async reset, high
  input  wire logic        WB_CYC_I,   // bus cycle
  input  wire logic        WB_STB_I,   // strobe
  input  wire logic        WB_WE_I,    // write enable
  input  wire logic [4:0]  WB_ADR_I,   // byte address
  input  wire logic [3:0]  WB_SEL_I,   // byte enables
  input  wire logic [31:0] WB_DAT_I,   // write data
  output logic      [31:0] WB_DAT_O,   // read data
  output logic             WB_ACK_O,   // acknowledge
  input  wire logic        PIN_C3_I,   // ch3_pin_third input level
  output logic             PIN_C3_O,   // ch3_pin_third output level
  output logic             PIN_C3_OE_N,// ch3_pin_third enable, low drives
  input  wire logic        PIN_A4_I,   // ch4_pin_first input level
  output logic             PIN_A4_O,   // ch4_pin_first output level
  output logic             PIN_A4_OE_N // ch4_pin_first enable, low drives
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ch3_low_io_control;
    logic [7:0]  ch4_io_control;
    logic [7:0]  ch3_mode_reg;
    logic [7:0]  count_ctrl;
    logic [15:0] ch3_general_reg_third;
    logic [15:0] ch4_general_reg_first;
    logic [15:0] ch3_general_reg_first;
    logic [15:0] ch3_counter;
    logic [15:0] ch4_counter;
    logic [2:0]  sync_c3;
    logic [2:0]  sync_a4;
    logic        lvl_c3;
    logic        lvl_a4;
    logic        pin_c3;
    logic        pin_a4;
    logic        oe_n_c3;
    logic        oe_n_a4;
    logic        ch4_counted;
    logic        ch3a_event;
    logic        ack;
    logic [31:0] rdata;
  } state_t;

  state_t st;
  state_t next_st;

  // decode: output enabled when compare mode and bits1:0 nonzero
  function automatic logic drives(input logic [3:0] f);
    drives = !f[3] && (f[1:0] != 2'b00);
  endfunction

  // decode: pin-edge capture strobe for a given field
  function automatic logic edge_hit(input logic [3:0] f, input logic rise, input logic fall);
    if (f[1]) begin
      edge_hit = rise | fall;
    end else if (f[0]) begin
      edge_hit = fall;
    end else begin
      edge_hit = rise;
    end
  endfunction

  // decode: next pin level on compare match
  function automatic logic match_level(input logic [1:0] m, input logic cur);
    case (m)
      2'b01:   match_level = 1'b0;
      2'b10:   match_level = 1'b1;
      2'b11:   match_level = ~cur;
      default: match_level = cur;
    endcase
  endfunction

  // initial level set up when a field is written
  function automatic logic init_level(input logic [3:0] f);
    init_level = f[2];
  endfunction

  logic [3:0] fc;
  logic [3:0] fa;
  logic       bus_req;
  logic       c3_rise;
  logic       c3_fall;
  logic       a4_rise;
  logic       a4_fall;
  logic       buf_mode;
  logic       match_c;
  logic       match_a4;
  logic       match_a3;
  logic       cap_c;
  logic       cap_a4;
  logic       ch4_step;
  logic       wr;
  logic [2:0] widx;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st  = st;
    fc       = st.ch3_low_io_control[3:0];
    fa       = st.ch4_io_control[3:0];
    buf_mode = st.ch3_mode_reg[BUFFER_MODE_A_BIT];
    bus_req  = WB_CYC_I && WB_STB_I && !st.ack;
    wr       = bus_req && WB_WE_I;
    widx     = WB_ADR_I[4:2];
    // pin synchronisers; changes count once stages 2 and 3 agree
    next_st.sync_c3 = {st.sync_c3[1:0], PIN_C3_I};
    next_st.sync_a4 = {st.sync_a4[1:0], PIN_A4_I};
    if (st.sync_c3[2] == st.sync_c3[1]) begin
      next_st.lvl_c3 = st.sync_c3[2];
    end
    if (st.sync_a4[2] == st.sync_a4[1]) begin
      next_st.lvl_a4 = st.sync_a4[2];
    end
    c3_rise = (st.sync_c3[2] == st.sync_c3[1]) && st.sync_c3[2] && !st.lvl_c3;
    c3_fall = (st.sync_c3[2] == st.sync_c3[1]) && !st.sync_c3[2] && st.lvl_c3;
    a4_rise = (st.sync_a4[2] == st.sync_a4[1]) && st.sync_a4[2] && !st.lvl_a4;
    a4_fall = (st.sync_a4[2] == st.sync_a4[1]) && !st.sync_a4[2] && st.lvl_a4;
    // counters
    ch4_step = st.count_ctrl[CNT_EN4_BIT];
    if (st.count_ctrl[CNT_EN3_BIT]) begin
      next_st.ch3_counter = st.ch3_counter + 16'h0001;
    end
    if (ch4_step) begin
      next_st.ch4_counter = st.count_ctrl[CNT_DOWN4_BIT] ? st.ch4_counter - 16'h0001
                                                       : st.ch4_counter + 16'h0001;
    end
    next_st.ch4_counted = ch4_step;
    // compare matches
    match_c  = !fc[3] && !buf_mode && (st.ch3_counter == st.ch3_general_reg_third);
    match_a4 = !fa[3] && (st.ch4_counter == st.ch4_general_reg_first);
    match_a3 = (st.ch3_counter == st.ch3_general_reg_first);
    next_st.ch3a_event = match_a3;
    // capture strobes
    if (fc[2]) begin
      cap_c = fc[3] && st.ch4_counted;
    end else begin
      cap_c = fc[3] && edge_hit(fc, c3_rise, c3_fall);
    end
    cap_c = cap_c && !buf_mode;
    if (fa[2]) begin
      cap_a4 = fa[3] && st.ch3a_event;
    end else begin
      cap_a4 = fa[3] && edge_hit(fa, a4_rise, a4_fall);
    end
    if (cap_c) begin
      next_st.ch3_general_reg_third = st.ch3_counter;
    end
    if (cap_a4) begin
      next_st.ch4_general_reg_first = st.ch4_counter;
    end
    // pin outputs on match
    if (match_c) begin
      next_st.pin_c3 = match_level(fc[1:0], st.pin_c3);
    end
    if (match_a4) begin
      next_st.pin_a4 = match_level(fa[1:0], st.pin_a4);
    end
    next_st.oe_n_c3 = !(drives(fc) && !buf_mode);
    next_st.oe_n_a4 = !drives(fa);
    // register writes; a field write sets the initial pin level
    next_st.ack = bus_req;
    if (wr && WB_SEL_I[0]) begin
      case (widx)
        3'd0: begin
          next_st.ch3_low_io_control = WB_DAT_I[7:0];
          next_st.pin_c3 = init_level(WB_DAT_I[3:0]);
        end
        3'd1: begin
          next_st.ch4_io_control = WB_DAT_I[7:0];
          next_st.pin_a4 = init_level(WB_DAT_I[3:0]);
        end
        3'd2: next_st.ch3_mode_reg = WB_DAT_I[7:0];
        3'd3: next_st.count_ctrl = WB_DAT_I[7:0];
        3'd4: next_st.ch3_general_reg_third[7:0] = WB_DAT_I[7:0];
        3'd5: next_st.ch4_general_reg_first[7:0] = WB_DAT_I[7:0];
        3'd6: next_st.ch3_general_reg_first[7:0] = WB_DAT_I[7:0];
        default: ;
      endcase
    end
    if (wr && WB_SEL_I[1]) begin
      case (widx)
        3'd4: next_st.ch3_general_reg_third[15:8] = WB_DAT_I[15:8];
        3'd5: next_st.ch4_general_reg_first[15:8] = WB_DAT_I[15:8];
        3'd6: next_st.ch3_general_reg_first[15:8] = WB_DAT_I[15:8];
        default: ;
      endcase
    end
    // read data
    case (widx)
      3'd0:    next_st.rdata = {24'h00_0000, st.ch3_low_io_control};
      3'd1:    next_st.rdata = {24'h00_0000, st.ch4_io_control};
      3'd2:    next_st.rdata = {24'h00_0000, st.ch3_mode_reg};
      3'd3:    next_st.rdata = {24'h00_0000, st.count_ctrl};
      3'd4:    next_st.rdata = {16'h0000, st.ch3_general_reg_third};
      3'd5:    next_st.rdata = {16'h0000, st.ch4_general_reg_first};
      3'd6:    next_st.rdata = {st.ch4_counter, st.ch3_counter};
      default: next_st.rdata = {28'h000_0000, st.lvl_a4, st.lvl_c3, st.pin_a4, st.pin_c3};
    endcase
    if (!bus_req) begin
      next_st.rdata = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st                       <= '0;
      st.ch3_low_io_control    <= IO_CONTROL_RESET;
      st.ch4_io_control        <= IO_CONTROL_RESET;
      st.ch3_mode_reg          <= MODE_RESET;
      st.ch3_general_reg_third <= GENERAL_RESET;
      st.ch4_general_reg_first <= GENERAL_RESET;
      st.ch3_general_reg_first <= GENERAL_RESET;
      st.ch3_counter           <= COUNTER_RESET;
      st.ch4_counter           <= COUNTER_RESET;
      st.oe_n_c3               <= 1'b1;
      st.oe_n_a4               <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign WB_DAT_O    = st.rdata;
  assign WB_ACK_O    = st.ack;
  assign PIN_C3_O    = st.pin_c3;
  assign PIN_C3_OE_N = st.oe_n_c3;
  assign PIN_A4_O    = st.pin_a4;
  assign PIN_A4_OE_N = st.oe_n_a4;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_disable;
    @(posedge CLOCK) disable iff (RST)
    (st.ch3_low_io_control[3:0] == 4'h0) |=> PIN_C3_OE_N;
  endproperty
  a_disable: assert property (p_disable) else $error("pin c3 driven while disabled");

  property p_init;
    @(posedge CLOCK) disable iff (RST)
    (WB_ACK_O == 1'b0 && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] && WB_ADR_I[4:2] == 3'd0)
      |=> (PIN_C3_O == $past(WB_DAT_I[2]));
  endproperty
  a_init: assert property (p_init) else $error("initial level wrong");

  property p_low;
    @(posedge CLOCK) disable iff (RST)
    (match_c && fc[1:0] == 2'b01 && !wr) |=> !PIN_C3_O;
  endproperty
  a_low: assert property (p_low) else $error("match did not drive low");

  property p_high;
    @(posedge CLOCK) disable iff (RST)
    (match_a4 && fa[1:0] == 2'b10 && !wr) |=> PIN_A4_O;
  endproperty
  a_high: assert property (p_high) else $error("match did not drive high");

  property p_toggle;
    @(posedge CLOCK) disable iff (RST)
    (match_c && fc[1:0] == 2'b11 && !wr) |=> (PIN_C3_O != $past(PIN_C3_O));
  endproperty
  a_toggle: assert property (p_toggle) else $error("match did not toggle");

  property p_cap_rise;
    @(posedge CLOCK) disable iff (RST)
    (fa == 4'b1000 && a4_rise && !wr) |=> (st.ch4_general_reg_first == $past(st.ch4_counter));
  endproperty
  a_cap_rise: assert property (p_cap_rise) else $error("rising capture missed");

  property p_cascade;
    @(posedge CLOCK) disable iff (RST)
    (fa[3:2] == 2'b11 && st.ch3a_event && !wr) |=> (st.ch4_general_reg_first == $past(st.ch4_counter));
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade capture missed");

  property p_drive;
    @(posedge CLOCK) disable iff (RST)
    (!fc[3] && fc[1:0] != 2'b00 && !buf_mode) |=> !PIN_C3_OE_N;
  endproperty
  a_drive: assert property (p_drive) else $error("pin c3 not driven in compare mode");

  property p_own_rise;
    @(posedge CLOCK) disable iff (RST)
    (fc == 4'b1000 && !buf_mode && c3_rise && !wr) |=> (st.ch3_general_reg_third == $past(st.ch3_counter));
  endproperty
  a_own_rise: assert property (p_own_rise) else $error("own pin capture missed");

  property p_cap_fall;
    @(posedge CLOCK) disable iff (RST)
    (fc == 4'b1001 && !buf_mode && c3_fall && !wr) |=> (st.ch3_general_reg_third == $past(st.ch3_counter));
  endproperty
  a_cap_fall: assert property (p_cap_fall) else $error("falling capture missed");

  property p_cap_both;
    @(posedge CLOCK) disable iff (RST)
    (fc[3:1] == 3'b101 && !buf_mode && (c3_rise || c3_fall) && !wr)
      |=> (st.ch3_general_reg_third == $past(st.ch3_counter));
  endproperty
  a_cap_both: assert property (p_cap_both) else $error("both-edge capture missed");

  property p_ch4_count;
    @(posedge CLOCK) disable iff (RST)
    (fc[3:2] == 2'b11 && !buf_mode && st.ch4_counted && !wr)
      |=> (st.ch3_general_reg_third == $past(st.ch3_counter));
  endproperty
  a_ch4_count: assert property (p_ch4_count) else $error("count capture missed");

  property p_buffer;
    @(posedge CLOCK) disable iff (RST)
    (buf_mode && !wr) |=> $stable(st.ch3_general_reg_third) && $stable(PIN_C3_O);
  endproperty
  a_buffer: assert property (p_buffer) else $error("buffer mode still acts");

  property p_ack;
    @(posedge CLOCK) disable iff (RST)
    (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
endmodule
`default_nettype wire

// [verilog/tpio_pkg.sv]
// Purpose: constants for the timer pin io mode select block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes:   offsets are byte addresses of aligned words
package tpio_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_CH3_LOW_IO_CONTROL = 5'h00;
  localparam logic [4:0] OFF_CH4_IO_CONTROL     = 5'h04;
  localparam logic [4:0] OFF_CH3_MODE_REG       = 5'h08;
  localparam logic [4:0] OFF_COUNT_CONTROL      = 5'h0C;
  localparam logic [4:0] OFF_CH3_GENERAL_C      = 5'h10;
  localparam logic [4:0] OFF_CH4_GENERAL_A      = 5'h14;
  localparam logic [4:0] OFF_CH3_GENERAL_A      = 5'h18;
  localparam logic [4:0] OFF_COUNTERS           = 5'h18;
  localparam logic [4:0] OFF_PIN_STATUS         = 5'h1C;
  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int         BUFFER_MODE_A_BIT = 4;
  localparam int         CNT_EN3_BIT       = 0;
  localparam int         CNT_EN4_BIT       = 1;
  localparam int         CNT_DOWN4_BIT     = 2;
  localparam logic [7:0] IO_CONTROL_RESET  = 8'h00;
  localparam logic [7:0] MODE_RESET        = 8'h00;
  localparam logic [15:0] GENERAL_RESET    = 16'hFFFF;
  localparam logic [15:0] COUNTER_RESET    = 16'h0000;
endpackage
